// File: rtl/dsfl_defines.vh
// Purpose: Constants for the loop switchover and fast lock controller
// Assumes: Included by rtl/dsfl_ctrl.v only
// Notes:   Register index sits in reg_addr[3:0], loop number in reg_addr[7:4]
`ifndef DSFL_DEFINES_VH
`define DSFL_DEFINES_VH
// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define DSFL_R_CTRL   4'h0
`define DSFL_R_PRIO   4'h1
`define DSFL_R_GROUP  4'h2
`define DSFL_R_SLOPE  4'h3
`define DSFL_R_FAST   4'h4
`define DSFL_R_FMISC  4'h5
`define DSFL_R_STAT   4'h6
// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define DSFL_CTRL_RST 32'h0000FF00
`define DSFL_PRIO_RST 32'h76543210
`define DSFL_ZERO     32'h00000000
`define DSFL_B_REV    0
`define DSFL_B_HSEN   1
`define DSFL_B_HST2   2
`define DSFL_B_PSLEN  3
`define DSFL_B_UNLIM  4
`define DSFL_B_PRE    8
`define DSFL_B_FSLEN  9
`define DSFL_B_WPSL   11
`define DSFL_O_MASK   8
`define DSFL_O_WSEL   10
`define DSFL_O_HI     16
`define DSFL_O_REC    4
// ----------------------------------------------------------------------
// Loop states
// ----------------------------------------------------------------------
`define DSFL_S_HOLD   3'h0
`define DSFL_S_HSW    3'h1
`define DSFL_S_ACQ    3'h2
`define DSFL_S_LOCK   3'h3
`define DSFL_S_REC    3'h4
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DSFL_CLK_PS   25000
`define DSFL_MS_PS    1000000000
`endif

// File: rtl/dsfl_ctrl.v
// Purpose: Reference switchover, hitless switch and fast lock control
// Assumes: Reference valid flags and lock detect are synchronous to core_clk
// Notes:   Loops 0..7 are indices 0..7, the system loop is index 8
//
// Functional notes
// - Each of loops 0 to 7 and the system loop switch independently.
// - Selection picks the highest priority valid reference, then locks.
// - Non-revertive after reset; revertive enabled per loop by software.
// - Non-revertive: switch only when present reference turns invalid.
// - Revertive: take better reference unless it shares the equal group.
// - Hitless switching enabled per loop by a setting.
// - Hitless fires on locked reference change and on leaving holdover.
// - Hitless switch passes temporary holdover without the alarm flag.
// - Measured initial phase offset becomes phase detector zero and stays.
// - Two hitless types selectable, type 2 frequency independent.
// - Phase slope limit enableable per loop, caps output phase rate.
// - Slope limit 1ns/s to 65.536us/s in 1ns/s steps.
// - Unlimited slope setting leaves rate to loop bandwidth.
// - Frequency deviation clamped to a programmable maximum offset.
// - Four fast lock options, each applied in acquire or recover state.
// - Precedence freq snap, phase snap, open loop, wide; middle two exclusive.
// - Frequency snap writes measured offset straight to the output divider.
// - Optional frequency slope limit restricts how fast the snap applies.
// - Phase snap jumps phase; open loop bypasses detector and filter.
// - Wide acquisition relaxes chosen settings until lock, then restores.
// - Acquire only: pre-acquisition max bandwidth for programmed ms first.
// - Reference qualified only when enabled and reported valid.
// - All references invalid puts the loop into holdover.
`timescale 1ns/1ps
`include "dsfl_defines.vh"
module dsfl_ctrl #(
  parameter NL     = 9,
  parameter NR     = 8,
  parameter RW     = 3,
  parameter PW     = 16,
  parameter FW     = 16,
  parameter MS_CYC = `DSFL_MS_PS / `DSFL_CLK_PS
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [7:0]       reg_addr,
  input  wire [31:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [31:0]      reg_rdata,
  input  wire [NR-1:0]    ref_valid,
  input  wire [NL-1:0]    lock_det,
  input  wire [NL*PW-1:0] phase_meas,
  input  wire [NL*FW-1:0] freq_meas,
  output wire [NL*RW-1:0] sel_ref,
  output wire [NL-1:0]    holdover_alarm,
  output wire [NL-1:0]    temp_holdover,
  output wire [NL*PW-1:0] pd_zero,
  output wire [NL-1:0]    hs_type2,
  output wire [NL*FW-1:0] fod_word,
  output wire [NL-1:0]    freq_snap,
  output wire [NL-1:0]    phase_snap,
  output wire [NL-1:0]    open_loop,
  output wire [NL-1:0]    wide_acq,
  output wire [NL*3-1:0]  wide_sel,
  output wire [NL-1:0]    pre_acq,
  output wire [NL*17-1:0] slope_lim,
  output wire [NL-1:0]    slope_unlim,
  output wire [NL*16-1:0] max_fo
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Best qualified reference: {found, index, priority}, 0 is top priority
  function [RW+4:0] best_ref;
    input [NR-1:0]   qual;
    input [NR*4-1:0] prio;
    integer          k;
    reg              fnd;
    reg   [RW-1:0]   idx;
    reg   [3:0]      pr;
    begin
      fnd = 1'b0;
      idx = {RW{1'b0}};
      pr  = 4'hF;
      for (k = 0; k < NR; k = k + 1)
        if (qual[k] && (!fnd || prio[k*4 +: 4] < pr))
        begin
          fnd = 1'b1;
          idx = k[RW-1:0];
          pr  = prio[k*4 +: 4];
        end
      best_ref = {fnd, idx, pr};
    end
  endfunction

  // Symmetric clamp of a signed word to +/- limit
  function [FW-1:0] clamp;
    input [FW-1:0] v;
    input [15:0]   lim;
    begin
      if ($signed(v) > $signed({1'b0, lim[FW-2:0]}))
        clamp = {1'b0, lim[FW-2:0]};
      else if ($signed(v) < -$signed({1'b0, lim[FW-2:0]}))
        clamp = -{1'b0, lim[FW-2:0]};
      else
        clamp = v;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  reg  [31:0]      ctrl_q  [0:NL-1];
  reg  [31:0]      prio_q  [0:NL-1];
  reg  [31:0]      group_q [0:NL-1];
  reg  [31:0]      slope_q [0:NL-1];
  reg  [31:0]      fast_q  [0:NL-1];
  reg  [31:0]      fmisc_q [0:NL-1];
  wire [NL*32-1:0] stat_w;
  wire [3:0]       loop_a = reg_addr[7:4];
  wire             loop_ok = (loop_a < NL);
  integer          n;

  // Software writes; ref enables reset on, policy resets non-revertive
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (n = 0; n < NL; n = n + 1)
      begin
        ctrl_q[n]  <= `DSFL_CTRL_RST;
        prio_q[n]  <= `DSFL_PRIO_RST;
        group_q[n] <= `DSFL_PRIO_RST;
        slope_q[n] <= `DSFL_ZERO;
        fast_q[n]  <= `DSFL_ZERO;
        fmisc_q[n] <= `DSFL_ZERO;
      end
    end
    else if (reg_wr && loop_ok)
    begin
      case (reg_addr[3:0])
        `DSFL_R_CTRL:  ctrl_q[loop_a]  <= reg_wdata;
        `DSFL_R_PRIO:  prio_q[loop_a]  <= reg_wdata;
        `DSFL_R_GROUP: group_q[loop_a] <= reg_wdata;
        `DSFL_R_SLOPE: slope_q[loop_a] <= reg_wdata;
        `DSFL_R_FAST:  fast_q[loop_a]  <= reg_wdata;
        `DSFL_R_FMISC: fmisc_q[loop_a] <= reg_wdata;
        default:       ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge core_clk)
  begin
    if (!rst_n || !reg_rd || !loop_ok)
      reg_rdata <= `DSFL_ZERO;
    else
    begin
      case (reg_addr[3:0])
        `DSFL_R_CTRL:  reg_rdata <= ctrl_q[loop_a];
        `DSFL_R_PRIO:  reg_rdata <= prio_q[loop_a];
        `DSFL_R_GROUP: reg_rdata <= group_q[loop_a];
        `DSFL_R_SLOPE: reg_rdata <= slope_q[loop_a];
        `DSFL_R_FAST:  reg_rdata <= fast_q[loop_a];
        `DSFL_R_FMISC: reg_rdata <= fmisc_q[loop_a];
        `DSFL_R_STAT:  reg_rdata <= stat_w[loop_a*32 +: 32];
        default:       reg_rdata <= `DSFL_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Per-loop control, one copy per loop
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NL; i = i + 1)
    begin : g_loop
      wire [31:0]   c  = ctrl_q[i];
      wire [31:0]   p  = prio_q[i];
      wire [31:0]   g  = group_q[i];
      wire [31:0]   s  = slope_q[i];
      wire [31:0]   f  = fast_q[i];
      wire [31:0]   fm = fmisc_q[i];
      reg  [2:0]    st_q;
      reg  [2:0]    pst_q;
      reg  [2:0]    dst_q;
      reg  [RW-1:0] cur_q;
      reg  [PW-1:0] pdz_q;
      reg  [FW-1:0] fod_q;
      reg  [1:0]    done_q;
      reg  [15:0]   ms_q;
      reg  [15:0]   sub_q;
      wire [NR-1:0] qual = ref_valid & c[`DSFL_O_MASK +: NR];
      wire [RW+4:0] b    = best_ref(qual, p[NR*4-1:0]);
      wire          fnd  = b[RW+4];
      wire [RW-1:0] bidx = b[RW+3:4];
      wire          cur_ok = qual[cur_q];
      wire          hs_en  = c[`DSFL_B_HSEN];
      // Equal-group members never displace each other
      wire          rev_go = c[`DSFL_B_REV] && fnd && (b[3:0] < p[cur_q*4 +: 4]) &&
                             (g[bidx*4 +: 4] != g[cur_q*4 +: 4]);
      // Options wait one cycle after entry so stale done flags never leak in
      wire          in_fl = ((st_q == `DSFL_S_ACQ) || (st_q == `DSFL_S_REC)) &&
                            (st_q == pst_q);
      wire          rec   = (st_q == `DSFL_S_REC);
      wire [3:0]    app;
      wire [FW-1:0] tgt   = clamp(freq_meas[i*FW +: FW], s[31:16]);
      wire [FW-1:0] step  = f[31:16];
      wire [FW-1:0] diff  = tgt - fod_q;
      wire          fa, pa, oa, pra, wa, tmp;

      // Option applies when enabled and its state choice matches
      assign app[0] = f[0] && (f[`DSFL_O_REC]   == rec) && in_fl;
      assign app[1] = f[1] && (f[`DSFL_O_REC+1] == rec) && in_fl;
      assign app[2] = f[2] && (f[`DSFL_O_REC+2] == rec) && in_fl;
      assign app[3] = f[3] && (f[`DSFL_O_REC+3] == rec) && in_fl;
      // Phase snap shadows open loop so both can never run together
      assign fa  = app[0] && !done_q[0];
      assign pa  = !fa && app[1] && !done_q[1];
      assign oa  = !fa && !app[1] && app[2];
      assign pra = !fa && !pa && !oa && app[3] && !rec &&
                   f[`DSFL_B_PRE] && (ms_q != 16'h0000);
      assign wa  = !fa && !pa && !oa && app[3] && !pra;
      assign tmp = pra || (wa && f[`DSFL_B_WPSL]);

      // Selection and switching state machine
      always @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          st_q  <= `DSFL_S_HOLD;
          dst_q <= `DSFL_S_ACQ;
          cur_q <= {RW{1'b0}};
          pdz_q <= {PW{1'b0}};
        end
        else
        begin
          case (st_q)
            `DSFL_S_HOLD:
            begin
              if (fnd)
              begin
                cur_q <= bidx;
                dst_q <= `DSFL_S_ACQ;
                st_q  <= hs_en ? `DSFL_S_HSW : `DSFL_S_ACQ;
              end
            end
            `DSFL_S_HSW:
            begin
              pdz_q <= phase_meas[i*PW +: PW];
              st_q  <= dst_q;
            end
            `DSFL_S_ACQ, `DSFL_S_REC:
            begin
              if (!cur_ok && fnd)
                cur_q <= bidx;
              else if (!cur_ok)
                st_q <= `DSFL_S_HOLD;
              else if (lock_det[i])
                st_q <= `DSFL_S_LOCK;
            end
            `DSFL_S_LOCK:
            begin
              // Without revert only a failing reference forces a move
              if (!cur_ok || rev_go)
              begin
                if (fnd)
                begin
                  cur_q <= bidx;
                  dst_q <= `DSFL_S_REC;
                  st_q  <= hs_en ? `DSFL_S_HSW : `DSFL_S_REC;
                end
                else
                  st_q <= `DSFL_S_HOLD;
              end
            end
            default: st_q <= `DSFL_S_HOLD;
          endcase
        end
      end

      // Fast lock sequencing, restarted on every state change
      always @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          pst_q  <= `DSFL_S_HOLD;
          fod_q  <= {FW{1'b0}};
          done_q <= 2'b00;
          ms_q   <= 16'h0000;
          sub_q  <= 16'h0000;
        end
        else
        begin
          pst_q <= st_q;
          if (st_q != pst_q)
          begin
            done_q <= 2'b00;
            ms_q   <= fm[15:0];
            sub_q  <= MS_CYC[15:0];
          end
          else
          begin
            if (fa)
            begin
              // Slope limited snap creeps in bounded steps per cycle
              if (f[`DSFL_B_FSLEN] && $signed(diff) > $signed(step))
                fod_q <= fod_q + step;
              else if (f[`DSFL_B_FSLEN] && $signed(diff) < -$signed(step))
                fod_q <= fod_q - step;
              else
              begin
                fod_q     <= tgt;
                done_q[0] <= 1'b1;
              end
            end
            if (pa)
              done_q[1] <= 1'b1;
            if (pra && sub_q <= 16'h0001)
            begin
              sub_q <= MS_CYC[15:0];
              ms_q  <= ms_q - 16'h0001;
            end
            else if (pra)
              sub_q <= sub_q - 16'h0001;
          end
        end
      end

      // Outputs and status word
      assign sel_ref[i*RW +: RW]     = cur_q;
      assign holdover_alarm[i]       = (st_q == `DSFL_S_HOLD);
      assign temp_holdover[i]        = (st_q == `DSFL_S_HSW);
      assign pd_zero[i*PW +: PW]     = pdz_q;
      assign hs_type2[i]             = c[`DSFL_B_HST2];
      assign fod_word[i*FW +: FW]    = fod_q;
      assign freq_snap[i]            = fa;
      assign phase_snap[i]           = pa;
      assign open_loop[i]            = oa;
      assign wide_acq[i]             = wa;
      assign wide_sel[i*3 +: 3]      = wa ? f[`DSFL_O_WSEL +: 3] : 3'h0;
      assign pre_acq[i]              = pra;
      // Stored value is limit minus one step, giving 1 to 65536 ns/s
      assign slope_lim[i*17 +: 17]   = tmp ? {1'b0, fm[31:16]} + 17'h00001 :
                                             {1'b0, s[15:0]} + 17'h00001;
      assign slope_unlim[i]          = !tmp && (!c[`DSFL_B_PSLEN] ||
                                                c[`DSFL_B_UNLIM]);
      assign max_fo[i*16 +: 16]      = s[31:16];
      assign stat_w[i*32 +: 32]      = {pdz_q, 5'h00, pra, oa, wa,
                                        (st_q == `DSFL_S_HOLD), cur_q, 1'b0, st_q};
    end
  endgenerate

endmodule

// File: verification/dsfl_ref_mon.sv
// Purpose: Reference monitor and lock detector stand-in
// Assumes: Watches the selected reference of every loop
// Notes:   Lock needs LK steady cycles, so it is never prompt
`timescale 1ns/1ps
module dsfl_ref_mon #(
  parameter NL = 9,
  parameter LK = 20
) (
  input  wire logic            core_clk,
  input  wire logic [7:0]      rv_cmd,
  input  wire logic            lock_en,
  input  wire logic [NL*3-1:0] sel_ref,
  output logic      [7:0]      ref_valid,
  output logic      [NL-1:0]   lock_det,
  output logic      [NL*16-1:0] phase_meas,
  output logic      [NL*16-1:0] freq_meas
);
  // ------------------------------------------------------------
  // Monitor flags and fixed measurements
  // ------------------------------------------------------------
  logic [NL*3-1:0] sel_q;
  int              cnt_q [NL];
  assign ref_valid  = rv_cmd;
  assign phase_meas = {NL{16'h0123}};
  assign freq_meas  = {NL{16'h0100}};
  initial
  begin
    lock_det = '0;
    foreach (cnt_q[i]) cnt_q[i] = 0;
  end
  // Lock drops at once when the chosen reference dies, restarts on a new choice
  always @(posedge core_clk)
  begin
    sel_q <= sel_ref;
    for (int i = 0; i < NL; i++)
    begin
      if (sel_ref[i*3+:3] != sel_q[i*3+:3]) cnt_q[i] <= 0;
      else if (cnt_q[i] < LK) cnt_q[i] <= cnt_q[i] + 1;
      lock_det[i] <= lock_en && cnt_q[i] >= LK && sel_ref[i*3+:3] == sel_q[i*3+:3] &&
                     rv_cmd[sel_ref[i*3+:3]];
    end
  end
endmodule

// File: verification/dsfl_ctrl_checker.sv
// Purpose: Port assertions for the switchover and fast lock controller
// Assumes: Loop 0 and loop 3 stand in for every loop
// Notes:   Slices assume 16 bit frequency words
`timescale 1ns/1ps
module dsfl_ctrl_checker #(
  parameter NL = 9,
  parameter NR = 8
) (
  input wire              core_clk,
  input wire              rst_n,
  input wire              reg_rd,
  input wire [31:0]       reg_rdata,
  input wire [NR-1:0]     ref_valid,
  input wire [NL-1:0]     lock_det,
  input wire [NL-1:0]     holdover_alarm,
  input wire [NL-1:0]     temp_holdover,
  input wire [NL*16-1:0]  fod_word,
  input wire [NL*16-1:0]  max_fo,
  input wire [NL-1:0]     freq_snap,
  input wire [NL-1:0]     phase_snap,
  input wire [NL-1:0]     open_loop,
  input wire [NL-1:0]     wide_acq,
  input wire [NL*3-1:0]   wide_sel,
  input wire [NL-1:0]     pre_acq
);
  // ------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hsw; temp_holdover[0] ##1 !temp_holdover[0]; endsequence
  sequence s_pre; (pre_acq[3] && !wide_acq[3])[*4]; endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_hsw; temp_holdover[0] |-> s_hsw; endproperty
  a_hsw: assert property (p_hsw) else $error("switch hold not one cycle");
  property p_noalarm; temp_holdover[0] |-> !holdover_alarm[0]; endproperty
  a_noalarm: assert property (p_noalarm) else $error("alarm in switch hold");
  property p_all_hold; (ref_valid == '0)[*3] |-> &holdover_alarm; endproperty
  a_all_hold: assert property (p_all_hold) else $error("loop not in hold");
  property p_leave; $fell(holdover_alarm[0]) |-> $past(ref_valid) != '0; endproperty
  a_leave: assert property (p_leave) else $error("left hold without reference");
  property p_lock_end; wide_acq[3] && lock_det[3] |-> ##[1:2] !wide_acq[3]; endproperty
  a_lock_end: assert property (p_lock_end) else $error("wide kept after lock");
  property p_snap; phase_snap[3] |=> !phase_snap[3]; endproperty
  a_snap: assert property (p_snap) else $error("phase snap not one cycle");
  property p_prec;
    (freq_snap[3] |-> !(phase_snap[3] || open_loop[3] || wide_acq[3]))
      and !(phase_snap[3] && open_loop[3]);
  endproperty
  a_prec: assert property (p_prec) else $error("fast lock order broken");
  property p_pre; $rose(pre_acq[3]) |-> s_pre; endproperty
  a_pre: assert property (p_pre) else $error("pre acquisition span wrong");
  property p_wsel; !wide_acq[3] |-> wide_sel[11:9] == 3'h0; endproperty
  a_wsel: assert property (p_wsel) else $error("wide select leaks");
  property p_fo;
    $stable(max_fo) |-> $signed(fod_word[63:48]) <= $signed({1'b0, max_fo[62:48]})
      && $signed(fod_word[63:48]) >= -$signed({1'b0, max_fo[62:48]});
  endproperty
  a_fo: assert property (p_fo) else $error("frequency word beyond limit");
endmodule
bind dsfl_ctrl dsfl_ctrl_checker #(.NL(NL), .NR(NR)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ref_valid(ref_valid), .lock_det(lock_det), .holdover_alarm(holdover_alarm),
  .temp_holdover(temp_holdover), .fod_word(fod_word), .max_fo(max_fo),
  .freq_snap(freq_snap), .phase_snap(phase_snap), .open_loop(open_loop),
  .wide_acq(wide_acq), .wide_sel(wide_sel), .pre_acq(pre_acq)
);

// File: verification/dsfl_ctrl_tb_top.sv
// Purpose: Self-checking bench for the switchover and fast lock controller
// Assumes: Millisecond count cut to 4 cycles, slow lock model
// Notes:   Rows step the reference flags; loops 0,1,2,5 are compared
`timescale 1ns/1ps
module dsfl_ctrl_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [7:0]   rv_cmd = 8'h00;
  wire  [31:0]  reg_rdata;
  wire  [7:0]   ref_valid;
  wire  [8:0]   lock_det, holdover_alarm, temp_holdover, hs_type2, freq_snap, phase_snap;
  wire  [8:0]   open_loop, wide_acq, pre_acq, slope_unlim;
  wire  [143:0] phase_meas, freq_meas, pd_zero, fod_word, max_fo;
  wire  [26:0]  sel_ref, wide_sel;
  wire  [152:0] slope_lim;
  logic [8:0]   s_th = '0, s_fs = '0, s_ps = '0, s_ol = '0, s_wa = '0, s_pa = '0;
  logic [2:0]   s_ws = 3'h0;
  logic [16:0]  s_sl = '0;
  int           n_th0 = 0;
  int           n_fs6 = 0;
  int           err_total = 0;
  int           checks = 0;
  // Reference flags, then expected choice of loops 0,1,2,5
  logic [19:0]  rows [3] = '{20'h0624A, 20'h07242, 20'h05002};
  initial forever #12.5 core_clk = ~core_clk;
  dsfl_ctrl #(.MS_CYC(4)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_valid(ref_valid),
    .lock_det(lock_det), .phase_meas(phase_meas), .freq_meas(freq_meas), .sel_ref(sel_ref),
    .holdover_alarm(holdover_alarm), .temp_holdover(temp_holdover), .pd_zero(pd_zero),
    .hs_type2(hs_type2), .fod_word(fod_word), .freq_snap(freq_snap), .phase_snap(phase_snap),
    .open_loop(open_loop), .wide_acq(wide_acq), .wide_sel(wide_sel), .pre_acq(pre_acq),
    .slope_lim(slope_lim), .slope_unlim(slope_unlim), .max_fo(max_fo));
  dsfl_ref_mon u_mon (
    .core_clk(core_clk), .rv_cmd(rv_cmd), .lock_en(1'b1), .sel_ref(sel_ref),
    .ref_valid(ref_valid), .lock_det(lock_det), .phase_meas(phase_meas),
    .freq_meas(freq_meas));
  // Sticky flags, since these events last only a cycle or a few;
  // held until reset has driven the outputs, so no unknown sticks
  always @(posedge core_clk)
  begin
    if (rst_n)
    begin
      s_th <= s_th | temp_holdover;
      s_fs <= s_fs | freq_snap;
      s_ps <= s_ps | phase_snap;
      s_ol <= s_ol | open_loop;
      s_wa <= s_wa | wide_acq;
      s_pa <= s_pa | pre_acq;
      n_th0 <= n_th0 + temp_holdover[0];
      n_fs6 <= n_fs6 + freq_snap[6];
      if (wide_acq[3]) s_ws <= wide_sel[11:9];
      if (pre_acq[3]) s_sl <= slope_lim[67:51];
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data is taken in the single slot after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", e, reg_rdata);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000FF00);
    rd(8'h01, 32'h76543210);
    rd(8'h02, 32'h76543210);
    rd(8'h03, 32'h00000000);
    rd(8'h04, 32'h00000000);
    rd(8'h05, 32'h00000000);
    wr(8'h06, 32'hFFFFFFFF);
    rd(8'h06, 32'h00000080);
    rd(8'h80, 32'h0000FF00);
    rd(8'h90, 32'h00000000);
    rd(8'h07, 32'h00000000);
    $display("test reset done");
    wr(8'h00, 32'h0000FF0E);
    wr(8'h03, 32'h0000FFFF);
    wr(8'h10, 32'h0000FF1B);
    wr(8'h12, 32'h76543200);
    wr(8'h20, 32'h0000FF01);
    wr(8'h33, 32'h00100000);
    wr(8'h34, 32'h0000150F);
    wr(8'h35, 32'h00070001);
    wr(8'h63, 32'h00100000);
    wr(8'h64, 32'h00040201);
    wr(8'h44, 32'h00000004);
    wr(8'h50, 32'h00000400);
    rd(8'h34, 32'h0000150F);
    repeat (2) @(posedge core_clk);
    cmp("hs_type2", 32'h001, {23'h0, hs_type2});
    cmp("slope_unlim", 32'h1FE, {23'h0, slope_unlim});
    cmp("slope_lim", 32'h10000, {15'h0, slope_lim[16:0]});
    cmp("max_fo", 32'h0010, {16'h0, max_fo[63:48]});
    $display("test config done");
    foreach (rows[i])
    begin
      @(posedge core_clk);
      rv_cmd <= rows[i][19:12];
      repeat (60) @(posedge core_clk);
      #1 cmp("sel_ref", {20'h0, rows[i][11:0]},
        {20'h0, sel_ref[2:0], sel_ref[5:3], sel_ref[8:6], sel_ref[17:15]});
      if (i == 0)
      begin
        cmp("pd_zero", 32'h0123, {16'h0, pd_zero[15:0]});
        cmp("fod_word", 32'h0010, {16'h0, fod_word[63:48]});
        cmp("fod_word6", 32'h0010, {16'h0, fod_word[111:96]});
      end
      $display("test row %0d done", i);
    end
    @(posedge core_clk);
    rv_cmd <= 8'h00;
    repeat (5) @(posedge core_clk);
    #1 cmp("holdover_alarm", 32'h1FF, {23'h0, holdover_alarm});
    cmp("switch_hold", 32'h3, {29'h0, s_th[2:0]});
    cmp("fast_flags", 32'h37,
      {26'h0, s_fs[3], s_ps[3], s_ol[3], s_wa[3], s_pa[3], s_ol[4]});
    // Hold exit in the first row, reference change in the last
    cmp("switch_count", 32'h2, n_th0);
    // Offset of 16 taken in steps of at most 4 needs four cycles
    cmp("fsl_cycles", 32'h4, n_fs6);
    cmp("slope_tmp", 32'h8, {15'h0, s_sl});
    cmp("wide_sel", 32'h5, {29'h0, s_ws});
    $display("test fast lock done");
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
endmodule
